// *** core/clock_routing_and_status_readback.sv ***
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module clock_routing_and_status_readback #(
    parameter int DIV_W = 10,
    parameter int CHAN_N = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic first_vco_divider_i,
    input wire logic second_vco_divider_i,
    input wire logic vcxo_clk_i,
    input wire logic [7:0] clock_lock_status_i,
    input wire logic vco_cal_busy_i,
    input wire logic selected_second_reference_i,
    input wire logic holdover_active_i,
    output logic [5:0] channel_out_clk_o,
    output logic [CHAN_N-1:0] channel_div_tick_o,
    output logic cleanup_loop_aux_clock_out_o,
    output logic aux_weak_drive_o,
    output logic aux_power_down_o
);
    // Refuse shapes the register layout cannot hold
    if (DIV_W < 1 || DIV_W > 16 || CHAN_N < 1 || CHAN_N > 4)
    begin : g_bad_param
        $error("Unsupported divider width or channel count");
    end

    typedef struct packed {
        logic [clk_route_pkg::PIN_N-1:0] sync1;
        logic [clk_route_pkg::PIN_N-1:0] sync2;
        logic [2:0] src_prev;
        logic [3:0] stat_prev;
        logic [7:0] ctl_lo;
        logic [7:0] ctl_hi;
        logic [CHAN_N-1:0][DIV_W-1:0] div_val;
        logic [CHAN_N-1:0][DIV_W-1:0] div_cnt;
        logic [CHAN_N-1:0] div_tick;
        logic [3:0] aux_cnt;
        logic aux_clk;
        logic [5:0] route_clk;
        logic [clk_route_pkg::IRQ_N-1:0] irq_sts;
        logic [clk_route_pkg::IRQ_N-1:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [clk_route_pkg::PIN_N-1:0] pins;
    logic [2:0] src_lvl;
    logic [2:0] src_edge;
    logic [7:0] rb0;
    logic [7:0] rb1;
    logic [3:0] stat_now;
    logic [clk_route_pkg::IRQ_N-1:0] irq_event;
    logic [5:0] sel6;
    logic [9:0] idx;
    logic req;
    logic wr;

    // Pin bundle, clocks in the low three bits
    assign pins = {holdover_active_i, selected_second_reference_i, vco_cal_busy_i,
                   clock_lock_status_i, vcxo_clk_i, second_vco_divider_i, first_vco_divider_i};
    assign src_lvl = state_reg.sync2[2:0];
    assign src_edge = src_lvl & ~state_reg.src_prev;
    // Live readback from the synchronised pins
    assign rb0 = state_reg.sync2[10:3];
    always_comb
    begin
        rb1 = 8'h00;
        rb1[clk_route_pkg::RB1_HOLD_BIT] = state_reg.sync2[13];
        rb1[clk_route_pkg::RB1_SELREF_BIT] = state_reg.sync2[12];
        rb1[clk_route_pkg::RB1_CAL_BIT] = state_reg.sync2[11];
    end
    // Lock, holdover and calibration levels for event detection
    assign stat_now = {state_reg.sync2[11], state_reg.sync2[13], state_reg.sync2[4], state_reg.sync2[3]};
    assign irq_event = {state_reg.stat_prev[3] & ~stat_now[3], stat_now[2] & ~state_reg.stat_prev[2],
                        state_reg.stat_prev[1] & ~stat_now[1], state_reg.stat_prev[0] & ~stat_now[0]};
    // Channel 4..9 select bits, bit j serves channel 4+j
    assign sel6 = {state_reg.ctl_hi[clk_route_pkg::CTL_HI_SEL_LSB+:3], state_reg.ctl_lo[clk_route_pkg::CTL_LO_SEL_LSB+:3]};
    assign idx = adr_i[11:2];
    assign req = cyc_i & stb_i & ~state_reg.ack;
    assign wr = req & we_i;

    // Next-state logic
    always_comb
    begin
        logic src_e;
        state_next = state_reg;
        src_e = 1'b0;
        state_next.sync1 = pins;
        state_next.sync2 = state_reg.sync1;
        state_next.src_prev = src_lvl;
        state_next.stat_prev = stat_now;
        // Channel outputs 4..9 from first or second VCO divider
        for (int j = 0; j < 6; j++)
        begin
            state_next.route_clk[j] = sel6[j] ? src_lvl[clk_route_pkg::SRC_SECOND] : src_lvl[clk_route_pkg::SRC_FIRST];
        end
        // Channel dividers count edges of VCXO or VCO divider output
        for (int i = 0; i < CHAN_N; i++)
        begin
            src_e = state_reg.ctl_hi[i] ? src_edge[clk_route_pkg::SRC_VCXO] : src_edge[clk_route_pkg::SRC_FIRST];
            state_next.div_tick[i] = 1'b0;
            if (src_e)
            begin
                // Wrap on reaching or passing the value, so a value lowered below the running count cannot stall
                if (state_reg.div_cnt[i] >= state_reg.div_val[i])
                begin
                    state_next.div_cnt[i] = '0;
                    state_next.div_tick[i] = 1'b1;
                end
                else
                begin
                    state_next.div_cnt[i] = state_reg.div_cnt[i] + 1'b1;
                end
            end
        end
        // Auxiliary output divides the VCXO clock
        if (src_edge[clk_route_pkg::SRC_VCXO])
        begin
            state_next.aux_cnt = state_reg.aux_cnt + 4'h1;
        end
        unique case (state_reg.ctl_lo[3:0])
            clk_route_pkg::AUX_DIV2: state_next.aux_clk = state_reg.aux_cnt[0];
            clk_route_pkg::AUX_DIV4: state_next.aux_clk = state_reg.aux_cnt[1];
            clk_route_pkg::AUX_DIV8: state_next.aux_clk = state_reg.aux_cnt[2];
            clk_route_pkg::AUX_DIV16: state_next.aux_clk = state_reg.aux_cnt[3];
            default: state_next.aux_clk = src_lvl[clk_route_pkg::SRC_VCXO];
        endcase
        // Sticky events, set wins over a write-one clear
        state_next.irq_sts = state_reg.irq_sts;
        if (wr && sel_i[0] && idx == clk_route_pkg::IDX_IRQ_STS)
        begin
            state_next.irq_sts = state_reg.irq_sts & ~dat_i[clk_route_pkg::IRQ_N-1:0];
        end
        state_next.irq_sts = state_next.irq_sts | irq_event;
        // Register writes
        if (wr && sel_i[0])
        begin
            if (idx == clk_route_pkg::IDX_CTL_LO)
            begin
                state_next.ctl_lo[7:4] = dat_i[7:4];
                if (dat_i[3:0] inside {clk_route_pkg::AUX_DIV1, clk_route_pkg::AUX_DIV2, clk_route_pkg::AUX_DIV4,
                                       clk_route_pkg::AUX_DIV8, clk_route_pkg::AUX_DIV16})
                begin
                    state_next.ctl_lo[3:0] = dat_i[3:0];
                end
            end
            if (idx == clk_route_pkg::IDX_CTL_HI)
            begin
                state_next.ctl_hi = dat_i[7:0];
            end
            if (idx == clk_route_pkg::IDX_IRQ_MASK)
            begin
                state_next.irq_mask = dat_i[clk_route_pkg::IRQ_N-1:0];
            end
        end
        for (int i = 0; i < CHAN_N; i++)
        begin
            if (wr && (&sel_i[1:0]) && idx == clk_route_pkg::IDX_DIV_BASE + 10'(i))
            begin
                state_next.div_val[i] = dat_i[DIV_W-1:0];
            end
        end
        // Read mux, unmapped reads as zero
        state_next.ack = req;
        state_next.rdata = 32'h0000_0000;
        if (req && !we_i)
        begin
            unique case (idx)
                clk_route_pkg::IDX_CTL_LO: state_next.rdata[7:0] = state_reg.ctl_lo;
                clk_route_pkg::IDX_CTL_HI: state_next.rdata[7:0] = state_reg.ctl_hi;
                clk_route_pkg::IDX_RB0: state_next.rdata[7:0] = rb0;
                clk_route_pkg::IDX_RB1: state_next.rdata[7:0] = rb1;
                clk_route_pkg::IDX_IRQ_STS: state_next.rdata[clk_route_pkg::IRQ_N-1:0] = state_reg.irq_sts;
                clk_route_pkg::IDX_IRQ_MASK: state_next.rdata[clk_route_pkg::IRQ_N-1:0] = state_reg.irq_mask;
                default:
                begin
                    for (int i = 0; i < CHAN_N; i++)
                    begin
                        if (idx == clk_route_pkg::IDX_DIV_BASE + 10'(i))
                        begin
                            state_next.rdata[DIV_W-1:0] = state_reg.div_val[i];
                        end
                    end
                end
            endcase
        end
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.ctl_lo <= clk_route_pkg::CTL_LO_RESET;
            state_reg.ctl_hi <= clk_route_pkg::CTL_HI_RESET;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign dat_o = state_reg.rdata;
    assign ack_o = state_reg.ack;
    assign irq_o = |(state_reg.irq_sts & state_reg.irq_mask);
    assign channel_out_clk_o = state_reg.route_clk;
    assign channel_div_tick_o = state_reg.div_tick;
    assign aux_weak_drive_o = state_reg.ctl_lo[clk_route_pkg::CTL_LO_WEAK_BIT];
    assign aux_power_down_o = state_reg.ctl_hi[clk_route_pkg::CTL_HI_PD_BIT];
    assign cleanup_loop_aux_clock_out_o = state_reg.aux_clk & ~aux_power_down_o;

    // Channel output 4..9 follows its selected source one cycle later
    a_route_select_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> channel_out_clk_o[0] == ($past(sel6[0]) ? $past(src_lvl[1]) : $past(src_lvl[0])))
        else $error("Channel 4 clock not from selected divider");
    a_route_high_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> channel_out_clk_o[5] == ($past(sel6[5]) ? $past(src_lvl[1]) : $past(src_lvl[0])))
        else $error("Channel 9 clock not from selected divider");
    a_weak_drive_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && sel_i[0] && idx == clk_route_pkg::IDX_CTL_LO |=> aux_weak_drive_o == $past(dat_i[4]))
        else $error("Drive strength did not follow write");
    a_aux_code_legal: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg.ctl_lo[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})
        else $error("Illegal auxiliary divider code held");
    a_aux_power_down: assert property (@(posedge clk_i) disable iff (rst_i)
        aux_power_down_o |-> !cleanup_loop_aux_clock_out_o)
        else $error("Auxiliary output runs while powered down");
    a_vcxo_route_count: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && state_reg.ctl_hi[0] && src_edge[2] && state_reg.div_cnt[0] < state_reg.div_val[0]
        |=> state_reg.div_cnt[0] == $past(state_reg.div_cnt[0]) + 1'b1)
        else $error("Channel 0 divider missed a VCXO edge");
    a_readback_live: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && !we_i && idx == clk_route_pkg::IDX_RB0 |=> ack_o && dat_o == {24'h0, $past(rb0)})
        else $error("First readback not live status");
    a_holdover_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && !we_i && idx == clk_route_pkg::IDX_RB1 |=> dat_o[3] == $past(state_reg.sync2[13]))
        else $error("Holdover bit wrong");
    a_selref_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && !we_i && idx == clk_route_pkg::IDX_RB1 |=> dat_o[2] == $past(state_reg.sync2[12]))
        else $error("Selected reference bit wrong");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && !we_i && idx == clk_route_pkg::IDX_RB1 |=> dat_o[7:4] == 4'h0 && !dat_o[1])
        else $error("Reserved readback bits not zero");
    a_readback_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && idx == clk_route_pkg::IDX_RB1 |=> $stable(state_reg.ctl_lo) && $stable(state_reg.ctl_hi))
        else $error("Readback write changed control");
    a_divider_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && src_edge[0] && !state_reg.ctl_hi[1] && state_reg.div_cnt[1] == state_reg.div_val[1]
        |=> channel_div_tick_o[1] && state_reg.div_cnt[1] == '0)
        else $error("Channel 1 divider did not wrap");
endmodule
`default_nettype wire

// *** pkg/clk_route_pkg.sv ***
package clk_route_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTL_LO = 10'h1BA;
    localparam logic [9:0] IDX_CTL_HI = 10'h1BB;
    localparam logic [9:0] IDX_RB0 = 10'h22C;
    localparam logic [9:0] IDX_RB1 = 10'h22D;
    localparam logic [9:0] IDX_IRQ_STS = 10'h240;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h241;
    localparam logic [9:0] IDX_DIV_BASE = 10'h250;
    // Low routing register fields
    localparam int CTL_LO_SEL_LSB = 5;
    localparam int CTL_LO_WEAK_BIT = 4;
    localparam logic [7:0] CTL_LO_RESET = 8'h01;
    // High routing register fields
    localparam int CTL_HI_PD_BIT = 7;
    localparam int CTL_HI_SEL_LSB = 4;
    localparam logic [7:0] CTL_HI_RESET = 8'h00;
    // Auxiliary divider codes
    localparam logic [3:0] AUX_DIV1 = 4'h0;
    localparam logic [3:0] AUX_DIV2 = 4'h1;
    localparam logic [3:0] AUX_DIV4 = 4'h2;
    localparam logic [3:0] AUX_DIV8 = 4'h4;
    localparam logic [3:0] AUX_DIV16 = 4'h8;
    // Second readback register fields
    localparam int RB1_HOLD_BIT = 3;
    localparam int RB1_SELREF_BIT = 2;
    localparam int RB1_CAL_BIT = 0;
    // Interrupt status bits
    localparam int IRQ_CLEANUP_UNLOCK = 0;
    localparam int IRQ_SYNTH_UNLOCK = 1;
    localparam int IRQ_HOLD_ENTER = 2;
    localparam int IRQ_CAL_DONE = 3;
    localparam int IRQ_N = 4;
    // Source pin order within the synchroniser
    localparam int SRC_FIRST = 0;
    localparam int SRC_SECOND = 1;
    localparam int SRC_VCXO = 2;
    localparam int PIN_N = 14;
endpackage

// *** sim/test_clock_routing_and_status_readback.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_clock_routing_and_status_readback;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o, irq_o, cleanup_loop_aux_clock_out_o, aux_weak_drive_o, aux_power_down_o;
    logic first_vco_divider_i = 1'b0, second_vco_divider_i = 1'b1, vcxo_clk_i = 1'b0;
    logic [7:0] clock_lock_status_i = 8'hFF;
    logic vco_cal_busy_i = 1'b1, selected_second_reference_i = 1'b0, holdover_active_i = 1'b0;
    logic [5:0] channel_out_clk_o;
    logic [3:0] channel_div_tick_o;
    logic run_first = 1'b0;
    int failures = 0, n_checks = 0, cycles = 0;

    clock_routing_and_status_readback #(.DIV_W(10), .CHAN_N(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .irq_o(irq_o), .first_vco_divider_i(first_vco_divider_i),
        .second_vco_divider_i(second_vco_divider_i), .vcxo_clk_i(vcxo_clk_i),
        .clock_lock_status_i(clock_lock_status_i), .vco_cal_busy_i(vco_cal_busy_i),
        .selected_second_reference_i(selected_second_reference_i), .holdover_active_i(holdover_active_i),
        .channel_out_clk_o(channel_out_clk_o), .channel_div_tick_o(channel_div_tick_o),
        .cleanup_loop_aux_clock_out_o(cleanup_loop_aux_clock_out_o), .aux_weak_drive_o(aux_weak_drive_o),
        .aux_power_down_o(aux_power_down_o));

    // 40 MHz system clock
    always #12.5 clk_i = ~clk_i;

    // Source clocks: VCXO rises every 8 cycles, first divider every 12 once enabled; timeout guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        vcxo_clk_i <= (cycles % 8) < 4;
        if (run_first)
            first_vco_divider_i <= (cycles % 12) < 6;
        if (cycles == 30000)
        begin
            failures = failures + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic [9:0] idx, input logic we, input logic [31:0] wd, input logic [3:0] sel,
        output logic [31:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= {idx, 2'b00};
        sel_i <= sel;
        dat_i <= wd;
        // Wait for ack however long it takes; only the cycle ceiling ends a hang
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        wb(idx, 1'b1, wd, 4'hF, d);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        wb(idx, 1'b0, 32'h0000_0000, 4'hF, d);
        check(d, exp);
    endtask

    // Cycles between two rising edges of the aux clock (0) or channel 0 tick (1)
    task automatic rise_gap(input logic which, output int gap);
        int n;
        logic p, s, found;
        p = 1'b1;
        found = 1'b0;
        gap = 0;
        for (n = 0; n < 600; n++)
        begin
            @(posedge clk_i);
            s = which ? channel_div_tick_o[0] : cleanup_loop_aux_clock_out_o;
            if (found)
                gap++;
            if (s === 1'b1 && p === 1'b0)
            begin
                if (found)
                    break;
                found = 1'b1;
            end
            p = s;
        end
    endtask

    task automatic steady_gap(input logic which, output int gap);
        rise_gap(which, gap);
        rise_gap(which, gap);
    endtask

    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    initial
    begin
        int g, i, highs;
        logic [31:0] d;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(clk_route_pkg::IDX_CTL_LO, 32'h0000_0001);
        rd_chk(clk_route_pkg::IDX_CTL_HI, 32'h0000_0000);
        wr(10'h100, 32'h0000_00FF);
        rd_chk(10'h100, 32'h0000_0000);
        // Channel outputs 4..9 follow the picked VCO divider
        wr(clk_route_pkg::IDX_CTL_LO, 32'h0000_00A1);
        wr(clk_route_pkg::IDX_CTL_HI, 32'h0000_0050);
        repeat (5) @(posedge clk_i);
        check(channel_out_clk_o, 6'h2D);
        first_vco_divider_i <= 1'b1;
        second_vco_divider_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check(channel_out_clk_o, 6'h12);
        rd_chk(clk_route_pkg::IDX_CTL_LO, 32'h0000_00A1);
        // Drive strength bit
        wr(clk_route_pkg::IDX_CTL_LO, 32'h0000_00B1);
        @(posedge clk_i);
        check(aux_weak_drive_o, 1'b1);
        wr(clk_route_pkg::IDX_CTL_LO, 32'h0000_0021);
        @(posedge clk_i);
        check(aux_weak_drive_o, 1'b0);
        // Every legal aux divider code, with its output period
        for (i = 0; i < 5; i++)
        begin
            wr(clk_route_pkg::IDX_CTL_LO, {28'h0000_000, codes[i]});
            rd_chk(clk_route_pkg::IDX_CTL_LO, {28'h0000_000, codes[i]});
            steady_gap(1'b0, g);
            check(g, 8 << i);
        end
        wr(clk_route_pkg::IDX_CTL_LO, 32'h0000_00A3);
        rd_chk(clk_route_pkg::IDX_CTL_LO, 32'h0000_00A8);
        wb(clk_route_pkg::IDX_CTL_LO, 1'b1, 32'h0000_0011, 4'h2, d);
        rd_chk(clk_route_pkg::IDX_CTL_LO, 32'h0000_00A8);
        // Power-down holds the aux clock low
        wr(clk_route_pkg::IDX_CTL_HI, 32'h0000_0080);
        @(posedge clk_i);
        check(aux_power_down_o, 1'b1);
        highs = 0;
        repeat (200)
        begin
            @(posedge clk_i);
            highs += (cleanup_loop_aux_clock_out_o !== 1'b0);
        end
        check(highs, 0);
        // Channel 0 divider from VCXO, then from the first VCO divider
        run_first <= 1'b1;
        wb(clk_route_pkg::IDX_DIV_BASE, 1'b1, 32'h0000_0002, 4'h3, d);
        rd_chk(clk_route_pkg::IDX_DIV_BASE, 32'h0000_0002);
        wr(clk_route_pkg::IDX_CTL_HI, 32'h0000_0001);
        steady_gap(1'b1, g);
        check(g, 24);
        wr(clk_route_pkg::IDX_CTL_HI, 32'h0000_0000);
        steady_gap(1'b1, g);
        check(g, 36);
        wb(clk_route_pkg::IDX_DIV_BASE, 1'b1, 32'h0000_0000, 4'h3, d);
        wr(clk_route_pkg::IDX_CTL_HI, 32'h0000_0001);
        steady_gap(1'b1, g);
        check(g, 8);
        // Live readback, writes ignored, reserved bits zero
        clock_lock_status_i <= 8'hA7;
        holdover_active_i <= 1'b1;
        selected_second_reference_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd_chk(clk_route_pkg::IDX_RB0, 32'h0000_00A7);
        rd_chk(clk_route_pkg::IDX_RB1, 32'h0000_000D);
        wr(clk_route_pkg::IDX_RB1, 32'h0000_00FF);
        clock_lock_status_i <= 8'h5B;
        holdover_active_i <= 1'b0;
        vco_cal_busy_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd_chk(clk_route_pkg::IDX_RB0, 32'h0000_005B);
        rd_chk(clk_route_pkg::IDX_RB1, 32'h0000_0004);
        // Interrupt events: raise, mask, unmask, clear
        wr(clk_route_pkg::IDX_IRQ_STS, 32'h0000_000F);
        clock_lock_status_i <= 8'h58;
        holdover_active_i <= 1'b1;
        vco_cal_busy_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        vco_cal_busy_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rd_chk(clk_route_pkg::IDX_IRQ_STS, 32'h0000_000F);
        check(irq_o, 1'b0);
        wr(clk_route_pkg::IDX_IRQ_MASK, 32'h0000_0004);
        @(posedge clk_i);
        check(irq_o, 1'b1);
        wr(clk_route_pkg::IDX_IRQ_STS, 32'h0000_0004);
        @(posedge clk_i);
        check(irq_o, 1'b0);
        rd_chk(clk_route_pkg::IDX_IRQ_STS, 32'h0000_000B);
        give_verdict();
    end
endmodule
`default_nettype wire
